// >>> design/pgfm_mux.sv
// The implementer's own choice: the strobed register port.
`timescale 1ns/1ps
`default_nettype none
`include "pgfm_map.svh"
module pgfm_mux (
    input wire logic clk,
    input wire logic rst,
    input wire pgfm_pkg::pgfm_req_t req,
    output logic [15:0] rdata,
    input wire pgfm_pkg::pgfm_src_t src,
    input wire logic rmii_ref_strap,
    output pgfm_pkg::pgfm_pins_t pins,
    output logic irq
);
    import pgfm_pkg::*;

    // ****************************************
    // state
    // ****************************************
    typedef struct packed {
        logic [15:0] light_indicator_config;
        logic [15:0] gpio_function_select_a;
        logic [15:0] gpio_function_select_b;
        logic [15:0] rdata;
        logic [1:0] stat;
        logic [1:0] en;
        logic [1:0] ev_d;
        logic strap;
        logic strap_s1;
        logic strap_s2;
        logic [1:0] strap_cnt;
        pgfm_pins_t pins;
        logic irq;
    } pgfm_state_t;

    pgfm_state_t cur;
    pgfm_state_t next_cur;

    // indicator condition chosen by a 4-bit source code
    function automatic logic light_src(input logic [3:0] code, input pgfm_src_t s);
        case (code)
            4'h0: light_src = s.link_up;
            4'h1: light_src = s.link_up & ~s.activity;
            4'h2: light_src = s.activity;
            4'h3: light_src = 1'b0;
            default: light_src = 1'b1;
        endcase
    endfunction

    // one pin's function from its select code
    function automatic logic pin_fn(input logic [2:0] sel, input logic light,
                                    input pgfm_src_t s);
        case (sel)
            `PGFM_SEL_LIGHT: pin_fn = light;
            `PGFM_SEL_CLOCK: pin_fn = s.ref_clock;
            `PGFM_SEL_WAKE: pin_fn = s.magic_packet_wake_event;
            `PGFM_SEL_LOWV: pin_fn = s.supply_low_alarm;
            `PGFM_SEL_TX_SFD: pin_fn = s.tx_sfd;
            `PGFM_SEL_RX_SFD: pin_fn = s.rx_sfd;
            `PGFM_SEL_LOW: pin_fn = 1'b0;
            default: pin_fn = 1'b1;
        endcase
    endfunction

    // ****************************************
    // next state
    // ****************************************
    always_comb
    begin
        logic [2:0] sa;
        logic [2:0] sb;
        logic [2:0] sc;
        logic [1:0] ev;
        logic [1:0] clr;
        next_cur = cur;
        sa = cur.gpio_function_select_a[`PGFM_SEL_A_PIN_A_LSB +: 3];
        sb = cur.gpio_function_select_a[`PGFM_SEL_A_PIN_B_LSB +: 3];
        sc = cur.gpio_function_select_b[`PGFM_SEL_B_PIN_C_LSB +: 3];
        ev = {src.supply_low_alarm, src.magic_packet_wake_event};
        clr = 2'h0;
        // register writes
        if (req.wr)
        begin
            case (req.addr)
                `PGFM_ADDR_LED_CFG: next_cur.light_indicator_config = req.wdata;
                `PGFM_ADDR_SEL_A: next_cur.gpio_function_select_a = req.wdata;
                `PGFM_ADDR_SEL_B: next_cur.gpio_function_select_b = req.wdata;
                `PGFM_ADDR_IRQ_CLR: clr = req.wdata[1:0];
                `PGFM_ADDR_IRQ_EN: next_cur.en = req.wdata[1:0];
                default: ;
            endcase
        end
        // register reads, data one cycle later
        next_cur.rdata = 16'h0000;
        if (req.rd)
        begin
            case (req.addr)
                `PGFM_ADDR_LED_CFG: next_cur.rdata = cur.light_indicator_config;
                `PGFM_ADDR_SEL_A: next_cur.rdata = cur.gpio_function_select_a;
                `PGFM_ADDR_SEL_B: next_cur.rdata = cur.gpio_function_select_b;
                `PGFM_ADDR_IRQ_STAT: next_cur.rdata = {14'h0000, cur.stat};
                `PGFM_ADDR_IRQ_EN: next_cur.rdata = {14'h0000, cur.en};
                default: next_cur.rdata = 16'h0000;
            endcase
        end
        // rising edge of wake and low supply sets sticky bits; set beats clear
        next_cur.ev_d = ev;
        next_cur.stat = (cur.stat & ~clr) | (ev & ~cur.ev_d);
        next_cur.irq = |(next_cur.stat & next_cur.en);
        // strap pin passes two flops, then is caught once on the third edge after reset
        next_cur.strap_s1 = rmii_ref_strap;
        next_cur.strap_s2 = cur.strap_s1;
        if (cur.strap_cnt != 2'h3)
        begin
            next_cur.strap_cnt = cur.strap_cnt + 2'h1;
            if (cur.strap_cnt == 2'h2)
            begin
                next_cur.strap = cur.strap_s2;
            end
        end
        // pin outputs
        next_cur.pins.indicator_pin_a =
            pin_fn(sa, light_src(cur.light_indicator_config[3:0], src), src);
        next_cur.pins.indicator_pin_b =
            pin_fn(sb, light_src(cur.light_indicator_config[7:4], src), src);
        next_cur.pins.indicator_pin_c =
            pin_fn(sc, light_src(cur.light_indicator_config[11:8], src), src);
        next_cur.pins.rx_d3_pin = cur.strap ? src.rmii_ref_clock : src.rx_d3;
    end

    // ****************************************
    // registers
    // ****************************************
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            cur <= '0;
            cur.light_indicator_config <= `PGFM_RST_LED_CFG;
            cur.gpio_function_select_a <= `PGFM_RST_SEL_A;
            cur.gpio_function_select_b <= `PGFM_RST_SEL_B;
        end
        else
        begin
            cur <= next_cur;
        end
    end

    assign rdata = cur.rdata;
    assign pins = cur.pins;
    assign irq = cur.irq;
endmodule
`default_nettype wire

// >>> design/pgfm_map.svh
`ifndef PGFM_MAP_SVH
`define PGFM_MAP_SVH
// Overview of operation
// - pin functions come from the two select registers at 0x0462 and 0x0463
// - indicator pins take their condition from the light config register at 0x0460
// - select 000 drives each pin with its own indicator channel
// - select 001 drives each pin with the clock output
// - pin b select 010 drives the wake event interrupt
// - pin b select 011 drives the supply low alarm interrupt
// - pin b select 110 holds the pin low
// - pin b select 111 holds the pin high
// - a pin function gives a pulse at each transmit start of frame
// - a pin function gives a pulse at each receive start of frame
// - a strap makes receive data pin 3 carry the 50 MHz reference clock
`define PGFM_ADDR_LED_CFG 16'h0460
`define PGFM_ADDR_SEL_A 16'h0462
`define PGFM_ADDR_SEL_B 16'h0463
`define PGFM_ADDR_IRQ_STAT 16'h0470
`define PGFM_ADDR_IRQ_CLR 16'h0471
`define PGFM_ADDR_IRQ_EN 16'h0472
`define PGFM_RST_LED_CFG 16'h0000
`define PGFM_RST_SEL_A 16'h0000
`define PGFM_RST_SEL_B 16'h0000
`define PGFM_SEL_A_PIN_A_LSB 0
`define PGFM_SEL_A_PIN_B_LSB 4
`define PGFM_SEL_B_PIN_C_LSB 0
`define PGFM_LED_SRC_W 4
`define PGFM_SEL_LIGHT 3'h0
`define PGFM_SEL_CLOCK 3'h1
`define PGFM_SEL_WAKE 3'h2
`define PGFM_SEL_LOWV 3'h3
`define PGFM_SEL_TX_SFD 3'h4
`define PGFM_SEL_RX_SFD 3'h5
`define PGFM_SEL_LOW 3'h6
`define PGFM_SEL_HIGH 3'h7
`endif

// >>> design/pgfm_pkg.sv
package pgfm_pkg;
    typedef struct packed {
        logic [15:0] addr;
        logic [15:0] wdata;
        logic wr;
        logic rd;
    } pgfm_req_t;
    typedef struct packed {
        logic link_up;
        logic activity;
        logic ref_clock;
        logic rmii_ref_clock;
        logic magic_packet_wake_event;
        logic supply_low_alarm;
        logic tx_sfd;
        logic rx_sfd;
        logic rx_d3;
    } pgfm_src_t;
    typedef struct packed {
        logic indicator_pin_a;
        logic indicator_pin_b;
        logic indicator_pin_c;
        logic rx_d3_pin;
    } pgfm_pins_t;
endpackage

// >>> tb/pgfm_far_model.sv
`timescale 1ns/1ps
`default_nettype none
module pgfm_far_model (
    input wire pgfm_pkg::pgfm_pins_t pins,
    input wire logic irq,
    output logic [4:0] seen
);
    import pgfm_pkg::*;
    // lamps and the host interrupt input just follow the driven pins
    assign seen = {pins, irq};
endmodule
`default_nettype wire

// >>> tb/pgfm_assertions.sv
`timescale 1ns/1ps
`default_nettype none
`include "pgfm_map.svh"
module pgfm_assertions (
    input wire logic clk,
    input wire logic rst,
    input wire pgfm_pkg::pgfm_req_t req,
    input wire logic [15:0] rdata,
    input wire pgfm_pkg::pgfm_src_t src,
    input wire logic rmii_ref_strap,
    input wire pgfm_pkg::pgfm_pins_t pins,
    input wire logic irq
);
    import pgfm_pkg::*;
    logic [15:0] sa, sb;
    logic [2:0] pa, pb, pc;
    logic [3:0] up;
    pgfm_src_t ps;
    default clocking @(posedge clk);
    endclocking
    default disable iff (rst);
    // shadow selects and sources, aged to line up with the pin flops
    always_ff @(posedge clk or posedge rst)
        if (rst)
            {sa, sb, pa, pb, pc, up, ps} <= '0;
        else
        begin
            if (req.wr && req.addr == `PGFM_ADDR_SEL_A)
                sa <= req.wdata;
            if (req.wr && req.addr == `PGFM_ADDR_SEL_B)
                sb <= req.wdata;
            {pa, pb, pc, up, ps} <= {sa[2:0], sa[6:4], sb[2:0], up[2:0], 1'b1, src};
        end
    // ****
    // checks
    // ****
    a_pa_clock: assert property (pa == 3'h1 |->
        pins.indicator_pin_a == ps.ref_clock) else $error("pin a clock");
    a_pb_wake: assert property (pb == 3'h2 |->
        pins.indicator_pin_b == ps.magic_packet_wake_event) else $error("pin b wake");
    a_pb_lowv: assert property (pb == 3'h3 |->
        pins.indicator_pin_b == ps.supply_low_alarm) else $error("pin b lowv");
    a_pb_const: assert property (pb[2:1] == 2'h3 |->
        pins.indicator_pin_b == pb[0]) else $error("pin b level");
    a_pa_tx_sfd: assert property (pa == 3'h4 |->
        pins.indicator_pin_a == ps.tx_sfd) else $error("pin a tx");
    a_pc_rx_sfd: assert property (pc == 3'h5 |->
        pins.indicator_pin_c == ps.rx_sfd) else $error("pin c rx");
    a_strap_clock: assert property (up[3] && rmii_ref_strap |->
        pins.rx_d3_pin == ps.rmii_ref_clock) else $error("rx d3 clock");
    a_read_idle: assert property (!$past(req.rd) |-> rdata == 16'h0000)
        else $error("rdata idle");
endmodule
bind pgfm_mux pgfm_assertions i_chk (.clk(clk), .rst(rst), .req(req), .rdata(rdata),
    .src(src), .rmii_ref_strap(rmii_ref_strap), .pins(pins), .irq(irq));
`default_nettype wire

// >>> tb/pgfm_mux_test.sv
`timescale 1ns/1ps
`default_nettype none
`include "pgfm_map.svh"
`define CHK(n, e, g) begin samples_checked++; if ((g) !== (e)) begin n_errors++; \
    $display("[FAIL] %s exp %h got %h", n, e, g); end end
module pgfm_mux_test;
    import pgfm_pkg::*;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic strap = 1'b0;
    pgfm_req_t req = '0;
    pgfm_src_t src = '0;
    pgfm_pins_t pins;
    logic [15:0] rdata;
    logic [15:0] cfg [2] = '{16'h0432, 16'h0510};
    logic irq;
    logic [4:0] seen;
    int n_errors = 0;
    int samples_checked = 0;
    // ****
    // bench
    // ****
    always #12.5 clk = ~clk;
    pgfm_mux i_dut (.clk(clk), .rst(rst), .req(req), .rdata(rdata), .src(src),
        .rmii_ref_strap(strap), .pins(pins), .irq(irq));
    pgfm_far_model i_far (.pins(pins), .irq(irq), .seen(seen));
    // verdict
    task automatic end_of_test();
        if (n_errors == 0 && samples_checked > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask
    // register port cycles
    task automatic wr(input logic [15:0] a, input logic [15:0] d);
        @(posedge clk) req <= '{a, d, 1'b1, 1'b0};
        @(posedge clk) req.wr <= 1'b0;
    endtask
    task automatic rd(input logic [15:0] a, input logic [15:0] e);
        @(posedge clk) req <= '{a, 16'h0000, 1'b0, 1'b1};
        @(posedge clk) req.rd <= 1'b0;
        #1 `CHK("rdata", e, rdata)
    endtask
    // expected pin level for a select code and light nibble
    function automatic logic fx(input logic [2:0] c, input logic [3:0] n, input pgfm_src_t s);
        case (c)
            3'h0: return n == 0 ? s.link_up : n == 1 ? s.link_up & !s.activity :
                n == 2 ? s.activity : n != 3;
            3'h1: return s.ref_clock;
            3'h2: return s.magic_packet_wake_event;
            3'h3: return s.supply_low_alarm;
            3'h4: return s.tx_sfd;
            3'h5: return s.rx_sfd;
            default: return c[0];
        endcase
    endfunction
    // watchdog
    initial
    begin
        #300000;
        n_errors++;
        end_of_test();
    end
    // two runs: strap off, then strap on after a second reset
    initial
    begin
        for (int s = 0; s < 2; s++)
        begin
            rst <= 1'b1;
            strap <= s[0];
            repeat (6) @(posedge clk);
            rst <= 1'b0;
            rd(`PGFM_ADDR_SEL_A, `PGFM_RST_SEL_A);
            rd(16'h0461, 16'h0000);
            for (int p = 0; p < 2; p++)
            begin
                src <= p ? 9'h0AA : 9'h155;
                wr(`PGFM_ADDR_LED_CFG, cfg[p]);
                for (int c = 0; c < 8; c++)
                begin
                    wr(`PGFM_ADDR_SEL_A, {9'h000, c[2:0], 1'b0, c[2:0]});
                    wr(`PGFM_ADDR_SEL_B, {13'h0000, c[2:0]});
                    rd(`PGFM_ADDR_SEL_B, {13'h0000, c[2:0]});
                    `CHK("pin a", fx(c[2:0], cfg[p][3:0], src), seen[4])
                    `CHK("pin b", fx(c[2:0], cfg[p][7:4], src), seen[3])
                    `CHK("pin c", fx(c[2:0], cfg[p][11:8], src), seen[2])
                    `CHK("rx d3", s ? src.rmii_ref_clock : src.rx_d3, seen[1])
                end
            end
            wr(`PGFM_ADDR_IRQ_CLR, 16'h0003);
            src <= '0;
            wr(`PGFM_ADDR_IRQ_EN, 16'h0001);
            src.magic_packet_wake_event <= 1'b1;
            repeat (3) @(posedge clk);
            #1 `CHK("irq", 1'b1, seen[0])
            rd(`PGFM_ADDR_IRQ_STAT, 16'h0001);
            wr(`PGFM_ADDR_IRQ_EN, 16'h0000);
            @(posedge clk) #1 `CHK("irq", 1'b0, seen[0])
            wr(`PGFM_ADDR_IRQ_CLR, 16'h0001);
            rd(`PGFM_ADDR_IRQ_STAT, 16'h0000);
        end
        end_of_test();
    end
endmodule
`default_nettype wire
